// [hdl/integer_multiply_unit.sv]
// Purpose: Integer multiply group and multiply-subtract execution with AXI4-Lite access
// Assumes: Instructions are issued by writing the instruction register
// Notes: Working registers, accumulators and data memory live inside this block
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module integer_multiply_unit
	import mulunit_pkg::*;
#(
	parameter int DMEM_WORDS = 4096
)(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write address
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// Write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// Write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read address
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// Read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);

	localparam int DW_A = $clog2(DMEM_WORDS);

	typedef struct packed {
		logic [15:0][15:0] w;
		logic [39:0] acca;
		logic [39:0] accb;
		logic int_mode;
		logic [23:0] instr;
		logic illegal;
		logic [15:0] count;
		logic aw_h;
		logic w_h;
		logic [ADDR_W-1:0] aw_a;
		logic [31:0] wd;
		logic [3:0] wsb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} state_t;

	typedef struct packed {
		logic en;
		logic ofs;
		logic [3:0] ptr;
		logic [15:0] delta;
	} pf_t;

	state_t s_r;
	state_t s_nxt;
	logic [15:0] dmem [DMEM_WORDS];
	logic mem_we;
	logic [DW_A-1:0] mem_idx;
	logic [15:0] mem_wd;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [DW_A-1:0] midx(input logic [15:0] a);
		return a[DW_A:1];
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] o, input logic [15:0] n,
			input logic [1:0] st);
		return {st[1] ? n[15:8] : o[15:8], st[0] ? n[7:0] : o[7:0]};
	endfunction

	// Prefetch field: none, plain, post-modify by +/-2/4/6, or base plus W12
	function automatic pf_t pf_dec(input logic [3:0] f, input logic yside);
		pf_t r;
		r.en = f != PF_NONE;
		r.ofs = f[2:0] == PF_REGOFS;
		r.ptr = {2'b10, yside, f[3]};
		unique case (f[2:0])
			3'h1: r.delta = 16'h0002;
			3'h2: r.delta = 16'h0004;
			3'h3: r.delta = 16'h0006;
			3'h5: r.delta = 16'hFFFA;
			3'h6: r.delta = 16'hFFFC;
			3'h7: r.delta = 16'hFFFE;
			default: r.delta = 16'h0000;
		endcase
		return r;
	endfunction

	// ****************************************
	// Instruction decode
	// ****************************************
	logic [23:0] opw;
	logic op_file;
	logic op_sreg;
	logic op_msub;
	logic [15:0] f_word;
	logic [7:0] f_byte;
	logic [15:0] bprod;
	logic [31:0] fprod;
	logic [3:0] rb;
	logic [3:0] rd;
	logic [2:0] pm;
	logic [3:0] rs;
	logic [15:0] base_val;
	logic [15:0] src_val;
	logic [15:0] src_pre;
	logic [15:0] src_post;
	logic [15:0] src_op;
	logic src_ok;
	logic dst_ok;
	logic signed [32:0] sprod;

	assign opw = s_r.wd[23:0];
	assign op_file = opw[23:16] == OPC_FILE && !opw[15] && !opw[13];
	assign op_sreg = opw[23:16] == OPC_SREG;
	assign op_msub = opw[23:19] == OPC_MAC_HI && opw[14] && opw[1:0] != WBACK_RSVD;

	// Word file operand is taken at the even address of the pair
	assign f_word = dmem[midx({3'h0, opw[FILE_W-1:0]})];
	assign f_byte = opw[0] ? f_word[15:8] : f_word[7:0];
	assign bprod = {8'h00, s_r.w[REG_DEFAULT][7:0]} * {8'h00, f_byte};
	assign fprod = {16'h0000, s_r.w[REG_DEFAULT]} * {16'h0000, f_word};

	assign rb = opw[14:11];
	assign rd = opw[10:7];
	assign pm = opw[6:4];
	assign rs = opw[3:0];
	assign base_val = s_r.w[rb];
	assign src_val = s_r.w[rs];
	// Pre-modify feeds the access, post-modify only the pointer
	assign src_pre = pm == MODE_PREDEC ? src_val - PTR_STEP :
		pm == MODE_PREINC ? src_val + PTR_STEP : src_val;
	assign src_post = pm == MODE_POSTDEC ? src_val - PTR_STEP :
		pm == MODE_POSTINC ? src_val + PTR_STEP : src_pre;
	assign src_op = pm[2:1] == MODE_LIT ? {11'h000, opw[4:0]} :
		pm == MODE_DIRECT ? src_val : dmem[midx(src_pre)];
	assign src_ok = !(pm[2:1] == MODE_LIT && opw[15]);
	assign dst_ok = !rd[0] && rd != DEST_FORBID;
	// Source sign bit only counts for signed-signed; the control bit is not used
	assign sprod = $signed(base_val) * $signed({opw[15] & src_op[15], src_op});

	// ****************************************
	// Multiply-subtract datapath
	// ****************************************
	logic pair_ok;
	logic [3:0] rm;
	logic [3:0] rn;
	logic signed [31:0] mprod;
	logic [31:0] mterm;
	logic [39:0] acc_tgt;
	logic [39:0] acc_oth;
	logic [39:0] acc_new;
	logic [15:0] rnd;
	pf_t pfx;
	pf_t pfy;
	logic [15:0] pfx_data;
	logic [15:0] pfy_data;

	// Operand pair select; codes 3 and 7 belong to other operations
	always_comb begin
		pair_ok = 1'b1;
		rm = 4'h4;
		rn = 4'h5;
		unique case (opw[18:16])
			3'h0: begin
				rm = 4'h4;
				rn = 4'h5;
			end
			3'h1: rn = 4'h6;
			3'h2: rn = 4'h7;
			3'h4: begin
				rm = 4'h5;
				rn = 4'h6;
			end
			3'h5: begin
				rm = 4'h5;
				rn = 4'h7;
			end
			3'h6: begin
				rm = 4'h6;
				rn = 4'h7;
			end
			default: pair_ok = 1'b0;
		endcase
	end

	assign mprod = $signed(s_r.w[rm]) * $signed(s_r.w[rn]);
	assign mterm = s_r.int_mode ? mprod : {mprod[30:0], 1'b0};
	assign acc_tgt = opw[15] ? s_r.accb : s_r.acca;
	assign acc_oth = opw[15] ? s_r.acca : s_r.accb;
	assign acc_new = acc_tgt - {{8{mterm[31]}}, mterm};
	// Other accumulator rounded to its middle word, half rounds up
	assign rnd = acc_oth[31:16] + {15'h0000, acc_oth[15]};
	assign pfx = pf_dec(opw[9:6], 1'b0);
	assign pfy = pf_dec(opw[5:2], 1'b1);
	assign pfx_data = dmem[midx(pfx.ofs ? 16'(s_r.w[pfx.ptr] + s_r.w[REG_OFS]) : s_r.w[pfx.ptr])];
	assign pfy_data = dmem[midx(pfy.ofs ? 16'(s_r.w[pfy.ptr] + s_r.w[REG_OFS]) : s_r.w[pfy.ptr])];

	// ****************************************
	// Next state
	// ****************************************
	logic exe;
	logic legal;
	logic [15:0] ca;
	logic [15:0] ra;

	assign legal = op_file || (op_sreg && src_ok && dst_ok) || (op_msub && pair_ok);
	assign ca = 16'(s_r.aw_a);
	assign ra = 16'(araddr);

	always_comb begin
		s_nxt = s_r;
		exe = 1'b0;
		mem_we = 1'b0;
		mem_idx = '0;
		mem_wd = '0;
		if (awvalid && s_r.awready) begin
			s_nxt.aw_h = 1'b1;
			s_nxt.aw_a = awaddr;
		end
		if (wvalid && s_r.wready) begin
			s_nxt.w_h = 1'b1;
			s_nxt.wd = wdata;
			s_nxt.wsb = wstrb;
		end
		if (s_r.bvalid && bready) begin
			s_nxt.bvalid = 1'b0;
		end
		// Address and data may arrive in either order; commit once both are held
		if (s_r.aw_h && s_r.w_h && !s_r.bvalid) begin
			s_nxt.aw_h = 1'b0;
			s_nxt.w_h = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = RESP_OKAY;
			if (ca[15:6] == OFS_WORKREG[15:6]) begin
				s_nxt.w[ca[5:2]] = merge16(s_r.w[ca[5:2]], s_r.wd[15:0], s_r.wsb[1:0]);
			end else if (ca >= OFS_DMEM && 32'((ca - OFS_DMEM) >> 2) < DMEM_WORDS) begin
				mem_we = 1'b1;
				mem_idx = ca[DW_A+1:2];
				mem_wd = merge16(dmem[ca[DW_A+1:2]], s_r.wd[15:0], s_r.wsb[1:0]);
			end else begin
				unique case (ca)
					OFS_CTRL: if (s_r.wsb[0]) s_nxt.int_mode = s_r.wd[CTRL_INT_BIT];
					OFS_INSTR: exe = 1'b1;
					OFS_ACCA_LO: s_nxt.acca[31:0] = {merge16(s_r.acca[31:16],
						s_r.wd[31:16], s_r.wsb[3:2]), merge16(s_r.acca[15:0],
						s_r.wd[15:0], s_r.wsb[1:0])};
					OFS_ACCA_HI: if (s_r.wsb[0]) s_nxt.acca[39:32] = s_r.wd[7:0];
					OFS_ACCB_LO: s_nxt.accb[31:0] = {merge16(s_r.accb[31:16],
						s_r.wd[31:16], s_r.wsb[3:2]), merge16(s_r.accb[15:0],
						s_r.wd[15:0], s_r.wsb[1:0])};
					OFS_ACCB_HI: if (s_r.wsb[0]) s_nxt.accb[39:32] = s_r.wd[7:0];
					default: s_nxt.bresp = RESP_SLVERR;
				endcase
			end
		end
		// Whole instruction retires at the commit edge; status keeps only the illegal flag and the count
		if (exe) begin
			s_nxt.instr = opw;
			s_nxt.count = s_r.count + 16'h0001;
			s_nxt.illegal = !legal;
			if (op_file) begin
				if (opw[14]) begin
					s_nxt.w[REG_PROD_LO] = bprod;
				end else begin
					s_nxt.w[REG_PROD_LO] = fprod[15:0];
					s_nxt.w[REG_PROD_HI] = fprod[31:16];
				end
			end else if (op_sreg && legal) begin
				s_nxt.w[rs] = src_post;
				s_nxt.w[rd] = sprod[15:0];
				s_nxt.w[{rd[3:1], 1'b1}] = sprod[31:16];
			end else if (op_msub && legal) begin
				if (opw[15]) begin
					s_nxt.accb = acc_new;
				end else begin
					s_nxt.acca = acc_new;
				end
				if (pfx.en) begin
					s_nxt.w[pfx.ptr] = s_r.w[pfx.ptr] + pfx.delta;
					s_nxt.w[REG_PF_BASE + {2'b00, opw[13:12]}] = pfx_data;
				end
				if (pfy.en) begin
					s_nxt.w[pfy.ptr] = s_r.w[pfy.ptr] + pfy.delta;
					s_nxt.w[REG_PF_BASE + {2'b00, opw[11:10]}] = pfy_data;
				end
				if (opw[1:0] == WBACK_REG) begin
					s_nxt.w[REG_WBACK] = rnd;
				end else if (opw[1:0] == WBACK_STORE) begin
					mem_we = 1'b1;
					mem_idx = midx(s_r.w[REG_WBACK]);
					mem_wd = rnd;
					s_nxt.w[REG_WBACK] = s_r.w[REG_WBACK] + PTR_STEP;
				end
			end
		end
		if (s_r.rvalid && rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (arvalid && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = RESP_OKAY;
			s_nxt.rdata = '0;
			if (ra[15:6] == OFS_WORKREG[15:6]) begin
				s_nxt.rdata = {16'h0000, s_r.w[ra[5:2]]};
			end else if (ra >= OFS_DMEM && 32'((ra - OFS_DMEM) >> 2) < DMEM_WORDS) begin
				s_nxt.rdata = {16'h0000, dmem[ra[DW_A+1:2]]};
			end else begin
				unique case (ra)
					OFS_CTRL: s_nxt.rdata = {31'h0000_0000, s_r.int_mode};
					OFS_INSTR: s_nxt.rdata = {8'h00, s_r.instr};
					OFS_STAT: s_nxt.rdata = {s_r.count, 15'h0000, s_r.illegal};
					OFS_ACCA_LO: s_nxt.rdata = s_r.acca[31:0];
					OFS_ACCA_HI: s_nxt.rdata = {24'h00_0000, s_r.acca[39:32]};
					OFS_ACCB_LO: s_nxt.rdata = s_r.accb[31:0];
					OFS_ACCB_HI: s_nxt.rdata = {24'h00_0000, s_r.accb[39:32]};
					default: s_nxt.rresp = RESP_SLVERR;
				endcase
			end
		end
		// One write and one read in flight; ready drops while an answer waits
		s_nxt.awready = !s_nxt.aw_h && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_h && !s_nxt.bvalid;
		s_nxt.arready = !s_nxt.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Memory stays out of reset; software loads it before use
	always_ff @(posedge aclk) begin
		if (mem_we) begin
			dmem[mem_idx] <= mem_wd;
		end
	end

	assign awready = s_r.awready;
	assign wready = s_r.wready;
	assign bvalid = s_r.bvalid;
	assign bresp = s_r.bresp;
	assign arready = s_r.arready;
	assign rvalid = s_r.rvalid;
	assign rresp = s_r.rresp;
	assign rdata = s_r.rdata;

	// ****************************************
	// Checks
	// ****************************************
	logic signed [31:0] chk_ss;
	logic signed [31:0] chk_sul;
	logic signed [32:0] chk_su;
	logic [3:0] hi_d;

	assign chk_ss = $signed(base_val) * $signed(src_val);
	assign chk_sul = $signed(base_val) * $signed({11'h000, opw[4:0]});
	assign chk_su = $signed(base_val) * $signed({1'b0, src_val});
	assign hi_d = {rd[3:1], 1'b1};

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_file_byte;
		exe && op_file && opw[14] |=> s_r.w[2] == $past(bprod);
	endproperty
	a_file_byte: assert property (p_file_byte) else $error("byte product wrong");

	property p_byte_w3;
		exe && op_file && opw[14] |=> $stable(s_r.w[3]);
	endproperty
	a_byte_w3: assert property (p_byte_w3) else $error("byte multiply touched W3");

	property p_file_word;
		exe && op_file && !opw[14] |=> {s_r.w[3], s_r.w[2]} == $past(fprod);
	endproperty
	a_file_word: assert property (p_file_word) else $error("word product wrong");

	property p_ss_direct;
		exe && op_sreg && opw[15] && pm == MODE_DIRECT && dst_ok && rs != hi_d
			|=> {s_r.w[$past(hi_d)], s_r.w[$past(rd)]} == $past(chk_ss);
	endproperty
	a_ss_direct: assert property (p_ss_direct) else $error("signed pair wrong");

	property p_su_lit;
		exe && op_sreg && !opw[15] && pm[2:1] == MODE_LIT && dst_ok
			|=> {s_r.w[$past(hi_d)], s_r.w[$past(rd)]} == $past(chk_sul);
	endproperty
	a_su_lit: assert property (p_su_lit) else $error("literal product wrong");

	property p_su_reg;
		exe && op_sreg && !opw[15] && pm == MODE_DIRECT && dst_ok && rs != hi_d
			|=> {s_r.w[$past(hi_d)], s_r.w[$past(rd)]} == $past(chk_su[31:0]);
	endproperty
	a_su_reg: assert property (p_su_reg) else $error("mixed product wrong");

	property p_bad_dest;
		exe && op_sreg && !dst_ok |=> $stable(s_r.w) && s_r.illegal;
	endproperty
	a_bad_dest: assert property (p_bad_dest) else $error("odd destination written");

	property p_msub_acc;
		exe && op_msub && pair_ok && !opw[15]
			|=> s_r.acca == $past(s_r.acca - {{8{mterm[31]}}, mterm});
	endproperty
	a_msub_acc: assert property (p_msub_acc) else $error("accumulator wrong");

	property p_msub_frac;
		exe && op_msub && pair_ok && !opw[15] && !s_r.int_mode
			|=> s_r.acca[0] == $past(s_r.acca[0]);
	endproperty
	a_msub_frac: assert property (p_msub_frac) else $error("fractional lsb moved");

	property p_wback;
		exe && op_msub && pair_ok && opw[1:0] == WBACK_REG |=> s_r.w[13] == $past(rnd);
	endproperty
	a_wback: assert property (p_wback) else $error("write-back wrong");

	property p_one_cycle;
		exe |=> s_r.count == $past(s_r.count) + 16'h0001 && s_r.bvalid;
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("instruction not retired");

	c_byte: cover property (exe && op_file && opw[14]);
	c_su_lit: cover property (exe && op_sreg && pm[2:1] == MODE_LIT && legal);
	c_msub_store: cover property (exe && op_msub && pair_ok && opw[1:0] == WBACK_STORE);

endmodule

// [hdl/mulunit_pkg.sv]
// Purpose: Constants for the integer multiply unit and its register window
// Assumes: 32-bit AXI4-Lite data, 16-bit working registers, 40-bit accumulators
// Notes: Offsets are byte addresses on the register bus
package mulunit_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int ADDR_W = 16;
	localparam logic [15:0] OFS_CTRL = 16'h0000;
	localparam logic [15:0] OFS_INSTR = 16'h0004;
	localparam logic [15:0] OFS_STAT = 16'h0008;
	localparam logic [15:0] OFS_WORKREG = 16'h0040;
	localparam logic [15:0] OFS_ACCA_LO = 16'h0080;
	localparam logic [15:0] OFS_ACCA_HI = 16'h0084;
	localparam logic [15:0] OFS_ACCB_LO = 16'h0088;
	localparam logic [15:0] OFS_ACCB_HI = 16'h008C;
	localparam logic [15:0] OFS_DMEM = 16'h4000;
	localparam int CTRL_INT_BIT = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// Opcode fields
	// ****************************************
	localparam logic [7:0] OPC_FILE = 8'hBC;
	localparam logic [7:0] OPC_SREG = 8'hB9;
	localparam logic [4:0] OPC_MAC_HI = 5'h18;
	localparam int FILE_W = 13;
	localparam logic [2:0] MODE_DIRECT = 3'h0;
	localparam logic [2:0] MODE_POSTDEC = 3'h2;
	localparam logic [2:0] MODE_POSTINC = 3'h3;
	localparam logic [2:0] MODE_PREDEC = 3'h4;
	localparam logic [2:0] MODE_PREINC = 3'h5;
	localparam logic [1:0] MODE_LIT = 2'h3;
	localparam logic [3:0] PF_NONE = 4'h4;
	localparam logic [2:0] PF_REGOFS = 3'h4;
	localparam logic [1:0] WBACK_REG = 2'h0;
	localparam logic [1:0] WBACK_STORE = 2'h1;
	localparam logic [1:0] WBACK_RSVD = 2'h3;

	// ****************************************
	// Working register roles
	// ****************************************
	localparam logic [3:0] REG_DEFAULT = 4'h0;
	localparam logic [3:0] REG_PROD_LO = 4'h2;
	localparam logic [3:0] REG_PROD_HI = 4'h3;
	localparam logic [3:0] REG_OFS = 4'hC;
	localparam logic [3:0] REG_WBACK = 4'hD;
	localparam logic [3:0] DEST_FORBID = 4'hE;
	localparam logic [3:0] REG_PF_BASE = 4'h4;
	localparam logic [15:0] PTR_STEP = 16'h0002;

endpackage

// [dv/axil_host.sv]
// Purpose: Register bus host standing in for the core that issues instructions
// Assumes: One write and one read at most under way; readys come from the unit
// Notes: A wait that runs past LIMIT edges raises hung for the bench to act on
`timescale 1ns/100ps
module axil_host
	import mulunit_pkg::*;
(
	// Clock
	input wire logic aclk,
	// Write channels
	output logic [ADDR_W-1:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// Read channels
	output logic [ADDR_W-1:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready,
	// Status
	output logic hung
);
	localparam int LIMIT = 50;

	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready, hung} = '0;
	end

	// ****************************************
	// Bus cycles
	// ****************************************
	// Address and data offered together; each dropped only once its own ready is seen
	task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) begin
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
			end
		end while (!bvalid && n < LIMIT);
		r = bresp;
		bready <= 1'b0;
		if (n >= LIMIT) begin
			hung <= 1'b1;
		end
	endtask

	task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) begin
				arvalid <= 1'b0;
			end
		end while (!rvalid && n < LIMIT);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n >= LIMIT) begin
			hung <= 1'b1;
		end
	endtask
endmodule

// [dv/tb.sv]
// Purpose: Self-checking bench for the integer multiply unit
// Assumes: Host model speaks the register bus; expectations worked out by hand
// Notes: Multiply-subtract cases chain, the second reuses the first accumulator
`timescale 1ns/100ps
module tb;
	import mulunit_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	wire logic [15:0] awaddr, araddr;
	wire logic [31:0] wdata, rdata;
	wire logic [3:0] wstrb;
	wire logic [1:0] bresp, rresp;
	wire logic awvalid, awready, wvalid, wready, bvalid, bready;
	wire logic arvalid, arready, rvalid, rready, hung;
	int mismatches = 0;
	int samples_checked = 0;
	int ops = 0;

	always #20 aclk = ~aclk;

	integer_multiply_unit dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready));

	axil_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.hung(hung));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge aclk) begin
		if (hung === 1'b1) begin
			mismatches++;
			stop_test();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic put(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		host.wr(a, d, r);
		chk("bresp", {30'h0, r}, {30'h0, er});
	endtask

	task automatic see(input string nm, input logic [15:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		host.rd(a, d, r);
		chk(nm, d, e);
	endtask

	task automatic setw(input int n, input logic [15:0] v);
		put(OFS_WORKREG + 16'(4 * n), {16'h0000, v}, RESP_OKAY);
	endtask

	task automatic seew(input string nm, input int n, input logic [15:0] v);
		see(nm, OFS_WORKREG + 16'(4 * n), {16'h0000, v});
	endtask

	// Core byte address to bus address of that data word
	task automatic mem(input logic [15:0] a, input logic [15:0] v);
		put(OFS_DMEM + {2'b00, a[12:1], 2'b00}, {16'h0000, v}, RESP_OKAY);
	endtask

	task automatic run(input logic [23:0] op);
		put(OFS_INSTR, {8'h00, op}, RESP_OKAY);
		ops++;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_file();
		setw(0, 16'h9823);
		setw(2, 16'hFFFF);
		setw(3, 16'hFFFF);
		mem(16'h0800, 16'h2690);
		run({OPC_FILE, 1'b0, 1'b1, 1'b0, 13'h0800});
		seew("byte_lo", 2, 16'h13B0);
		seew("byte_hi", 3, 16'hFFFF);
		setw(0, 16'hF001);
		mem(16'h1FFE, 16'h3287);
		run({OPC_FILE, 3'b000, 13'h1FFE});
		seew("word_lo", 2, 16'hC287);
		seew("word_hi", 3, 16'h2F5E);
		$display("done file multiply");
	endtask

	task automatic t_signed();
		setw(0, 16'h9823);
		setw(1, 16'h67DC);
		run({8'hB9, 1'b1, 4'd0, 4'd12, 3'd0, 4'd1});
		seew("ss_lo", 12, 16'hD314);
		seew("ss_hi", 13, 16'hD5DC);
		setw(2, 16'h0045);
		setw(4, 16'h27FE);
		mem(16'h27FC, 16'h0098);
		run({8'hB9, 1'b1, 4'd2, 4'd0, MODE_PREDEC, 4'd4});
		seew("ssi_lo", 0, 16'h28F8);
		seew("ssi_hi", 1, 16'h0000);
		seew("ssi_ptr", 4, 16'h27FC);
		setw(8, 16'hF000);
		setw(9, 16'h178C);
		mem(16'h178C, 16'hF000);
		run({8'hB9, 1'b0, 4'd8, 4'd0, 3'd1, 4'd9});
		seew("su_lo", 0, 16'h0000);
		seew("su_hi", 1, 16'hF100);
		run({8'hB9, 1'b0, 4'd8, 4'd2, 3'd0, 4'd9});
		seew("sud_lo", 2, 16'h4000);
		seew("sud_hi", 3, 16'hFE87);
		$display("done signed multiply");
	endtask

	// Same literal multiply in fractional then integer mode must agree
	task automatic t_literal();
		int i;
		for (i = 0; i < 2; i++) begin
			put(OFS_CTRL, 32'(i), RESP_OKAY);
			setw(0, 16'hC000);
			run({8'hB9, 1'b0, 4'd0, 4'd2, MODE_LIT, 5'd31});
			seew("lit_lo", 2, 16'h4000);
			seew("lit_hi", 3, 16'hFFF8);
		end
		run({8'hB9, 1'b0, 4'd0, 4'd2, MODE_LIT, 5'd0});
		seew("lit0_hi", 3, 16'h0000);
		$display("done literal multiply");
	endtask

	task automatic t_illegal();
		setw(14, 16'h1111);
		setw(15, 16'h2222);
		run({8'hB9, 1'b1, 4'd0, 4'd14, 3'd0, 4'd1});
		seew("w14", 14, 16'h1111);
		seew("w15", 15, 16'h2222);
		see("stat_bad", OFS_STAT, {16'(ops), 16'h0001});
		setw(4, 16'h7777);
		run({8'hB9, 1'b1, 4'd0, 4'd3, 3'd0, 4'd1});
		seew("w4", 4, 16'h7777);
		run({8'hB9, 1'b1, 4'd0, 4'd4, 3'd0, 4'd1});
		see("stat_ok", OFS_STAT, {16'(ops), 16'h0000});
		$display("done illegal destination");
	endtask

	task automatic t_msub();
		put(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
		setw(6, 16'h9051);
		setw(7, 16'h7230);
		setw(8, 16'h0C00);
		setw(10, 16'h1C00);
		mem(16'h0C00, 16'hD309);
		mem(16'h1C00, 16'h100B);
		put(OFS_ACCA_LO, 32'h0567_8000, RESP_OKAY);
		put(OFS_ACCA_HI, 32'h0000_0000, RESP_OKAY);
		run({OPC_MAC_HI, 3'd6, 1'b0, 1'b1, 2'd2, 2'd3, 4'b0110, 4'b0110, 2'b10});
		see("acca_lo", OFS_ACCA_LO, 32'h3738_5ED0);
		see("acca_hi", OFS_ACCA_HI, 32'h0000_0000);
		seew("pf_x", 6, 16'hD309);
		seew("pf_y", 7, 16'h100B);
		seew("ptr_x", 8, 16'h0BFC);
		seew("ptr_y", 10, 16'h1BFC);
		put(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
		setw(4, 16'h0500);
		setw(5, 16'h2000);
		setw(11, 16'h0800);
		setw(12, 16'h0800);
		setw(13, 16'h6233);
		mem(16'h1000, 16'h3579);
		put(OFS_ACCB_LO, 32'h1000_0000, RESP_OKAY);
		put(OFS_ACCB_HI, 32'h0000_0000, RESP_OKAY);
		run({OPC_MAC_HI, 3'd0, 1'b1, 1'b1, 2'd0, 2'd1, PF_NONE, 4'b1100, 2'b00});
		see("accb_lo", OFS_ACCB_LO, 32'h0EC0_0000);
		seew("pf_ofs", 5, 16'h3579);
		seew("wback", 13, 16'h3738);
		seew("w11", 11, 16'h0800);
		$display("done multiply-subtract");
	endtask

	// A refused write must not change the count; unmapped read returns zero
	task automatic t_bus();
		logic [31:0] d;
		logic [1:0] r;
		put(OFS_STAT, 32'h0000_0000, RESP_SLVERR);
		see("stat_cnt", OFS_STAT, {16'(ops), 16'h0000});
		host.rd(16'h0100, d, r);
		chk("unmapped", {r, d[29:0]}, {RESP_SLVERR, 30'h0});
		$display("done bus refusals");
	endtask

	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		seew("w2_rst", 2, 16'h0000);
		see("ctrl_rst", OFS_CTRL, 32'h0000_0000);
		t_file();
		t_signed();
		t_literal();
		t_illegal();
		t_msub();
		t_bus();
		stop_test();
	end
endmodule
